// File: core/imc_pkg.sv
// Constants, field positions and carrier types for the group unmask and source view block.
// Assumes a 32-bit AXI4-Lite register bus and request lines on the same clock.
package imc_pkg;
  localparam logic [31:0] ADDR_ITMR_VIEW  = 32'hfffff440;
  localparam logic [31:0] ADDR_DMA_VIEW   = 32'hfffff444;
  localparam logic [31:0] ADDR_CAP_VIEW   = 32'hfffff448;
  localparam logic [31:0] ADDR_UNF_VIEW   = 32'hfffff44c;
  localparam logic [31:0] ADDR_MASK_ONE   = 32'hfffff4d0;
  localparam logic [31:0] ADDR_UNMASK_ONE = 32'hfffff4d4;
  localparam logic [31:0] RST_VIEW        = 32'h00000000;
  localparam logic [31:0] RST_UNMASK_ONE  = 32'h00000000;
  localparam logic [31:0] RST_MASK_ONE    = 32'hffffffff;
  localparam logic [31:0] MASK_ONE_IMPL   = 32'h00077fff;
  localparam logic [31:0] MASK_ONE_TT_BUS = 32'h00030000;
  localparam int POS_PERIPH_DATA_ACCESS_GROUP      = 18;
  localparam int POS_TT_TIMER  = 17;
  localparam int POS_TT_CTRL   = 16;
  localparam int POS_CAN_LO    = 10;
  localparam int POS_OUT_LO    = 0;
  localparam int POS_ITMR_LO   = 0;
  localparam int POS_DMA_DN_HI = 12;
  localparam int POS_DMA_HF_HI = 8;
  localparam int POS_DMA_DN_LO = 6;
  localparam int POS_DMA_AERR  = 4;
  localparam int POS_DMA_HF_LO = 0;
  localparam int POS_TG_CMP    = 24;
  localparam int POS_TF_OVF    = 20;
  localparam int POS_TF_CAP    = 16;
  localparam int POS_TA1_OVF   = 14;
  localparam int POS_TA1_CAP   = 8;
  localparam int POS_TA0_OVF   = 6;
  localparam int POS_TA0_CAP   = 0;
  localparam int POS_UNF_LO    = 0;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [2:0]  interval_timer_underflow;
    logic [1:0]  dma_ch11_10_done;
    logic [3:0]  dma_ch9_6_done_or_half;
    logic [1:0]  dma_ch5_4_done;
    logic [1:0]  dma_ctrl_addr_error;
    logic [3:0]  dma_ch3_0_done_or_half;
    logic [5:0]  timer_g_compare_match;
    logic [3:0]  timer_f_overflow;
    logic [3:0]  timer_f_capture;
    logic        timer_a1_overflow;
    logic [5:0]  timer_a1_capture;
    logic        timer_a0_overflow;
    logic [5:0]  timer_a0_capture;
    logic [23:0] out_unit_underflow;
  } imc_src_s;

  typedef struct packed {
    logic       periph_data_access_group;
    logic       tt_bus_timer_group;
    logic       tt_bus_ctrl_group;
    logic [4:0] can_group;
    logic [9:0] out_unit_group;
  } imc_grp_s;

  typedef enum logic [1:0] {
    IMC_WR_IDLE = 2'b00,
    IMC_WR_RESP = 2'b01
  } imc_wr_e;

  typedef enum logic [1:0] {
    IMC_RD_IDLE = 2'b00,
    IMC_RD_DATA = 2'b01
  } imc_rd_e;
endpackage

// File: core/imc_irq_view.sv
// Group unmask strobe, second group mask and four detailed source views on AXI4-Lite.
// Assumes request lines come from logic on aclk and stay high while a request is active.
// Notes on behaviour
// [RULE1] Writing one to an implemented unmask bit clears that group's mask bit.
// [RULE2] The unmask strobe register always reads back as zero.
// [RULE3] Unmask bits written as zero leave their mask bits unchanged.
// [RULE4] Software writes zero to unmask bits 31 to 19 and 15.
// [RULE5] Unmask bits 18, 17, 16 select data-access, bus timer, bus controller groups.
// [RULE6] Without the bus controller, bits 17 and 16 are reserved, written zero.
// [RULE7] Unmask bits 14 down to 10 select CAN groups 4 down to 0.
// [RULE8] Unmask bits 9 down to 0 select output-unit channel quads, unit 4 first.
// [RULE9] Unmask strobe and all source views reset to zero.
// [RULE10] Source views ignore both group mask registers.
// [RULE11] Individual sources are suppressed inside the originating peripheral.
// [RULE12] A source bit reads one while active, zero otherwise, even when masked.
// [RULE13] View 0 holds interval timer underflows 2..0 in bits 2..0, rest zero.
// [RULE14] View 1 bits 13,12 and 7,6 hold done of DMA 11,10 and 5,4.
// [RULE15] View 1 bits 11..8, 3..0 hold done-or-half of DMA 9..6, 3..0.
// [RULE16] View 1 bit 5 and bit 4 hold address errors of controllers 1 and 0.
// [RULE17] View 2 bits 29..24 hold timer G compare matches 5..0, 31..30 zero.
// [RULE18] View 2 bits 23..20 hold timer F overflows 3..0.
// [RULE19] View 2 bits 19..16 hold timer F captures 3..0.
// [RULE20] View 2 bit 14 timer A1 overflow, bits 13..8 its captures, 15 zero.
// [RULE21] View 2 bit 6 timer A0 overflow, bits 5..0 its captures, 7 zero.
// [RULE22] View 3 bits 23..0 hold output units 2..0 channel underflows.
// [RULE23] Groups masked by a one are not signalled; mask resets to all ones.
// [RULE24] Source bits follow their request levels and never clear by writes.
// [RULE25] Writes to source views are ignored; unused view bits read zero.
`timescale 1ns/10ps
module imc_irq_view #(
  parameter bit HAS_TT_BUS = 1'b1
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              wvalid,
  output      logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output      logic              bvalid,
  input  wire logic              bready,
  output      logic [1:0]        bresp,
  input  wire logic              arvalid,
  output      logic              arready,
  input  wire logic [31:0]       araddr,
  input  wire logic [2:0]        arprot,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  input  wire imc_pkg::imc_src_s src_req,
  input  wire imc_pkg::imc_grp_s grp_req,
  output      imc_pkg::imc_grp_s grp_notify
);

  // Register select codes, one-hot
  localparam int SEL_W = 6;

  function automatic logic [SEL_W-1:0] reg_hit(input logic [31:0] a);
    logic [SEL_W-1:0] h;
    h = '0;
    if (a[31:2] == imc_pkg::ADDR_ITMR_VIEW[31:2])
    begin
      h[0] = 1'b1;
    end
    else if (a[31:2] == imc_pkg::ADDR_DMA_VIEW[31:2])
    begin
      h[1] = 1'b1;
    end
    else if (a[31:2] == imc_pkg::ADDR_CAP_VIEW[31:2])
    begin
      h[2] = 1'b1;
    end
    else if (a[31:2] == imc_pkg::ADDR_UNF_VIEW[31:2])
    begin
      h[3] = 1'b1;
    end
    else if (a[31:2] == imc_pkg::ADDR_MASK_ONE[31:2])
    begin
      h[4] = 1'b1;
    end
    else if (a[31:2] == imc_pkg::ADDR_UNMASK_ONE[31:2])
    begin
      h[5] = 1'b1;
    end
    return h;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // State
  imc_pkg::imc_wr_e  wr_state_ff;
  imc_pkg::imc_wr_e  nxt_wr_state;
  imc_pkg::imc_rd_e  rd_state_ff;
  imc_pkg::imc_rd_e  nxt_rd_state;
  logic              aw_held_ff;
  logic              nxt_aw_held;
  logic              w_held_ff;
  logic              nxt_w_held;
  logic [31:0]       waddr_ff;
  logic [31:0]       nxt_waddr;
  logic [31:0]       wdata_ff;
  logic [31:0]       nxt_wdata;
  logic [3:0]        wstrb_ff;
  logic [3:0]        nxt_wstrb;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;
  logic [31:0]       mask_one_ff;
  logic [31:0]       nxt_mask_one;
  logic [31:0]       view_ff [4];
  logic [31:0]       nxt_view [4];
  imc_pkg::imc_grp_s notify_ff;
  imc_pkg::imc_grp_s nxt_notify;

  // Decode
  wire logic              aw_take;
  wire logic              w_take;
  wire logic              ar_take;
  wire logic              wr_go;
  wire logic [31:0]       wr_addr;
  wire logic [31:0]       wr_data;
  wire logic [3:0]        wr_strb;
  wire logic [SEL_W-1:0]  wr_hit;
  wire logic [SEL_W-1:0]  rd_hit;
  wire logic [31:0]       wr_bits;
  wire logic [31:0]       impl_bits;
  wire logic [31:0]       fixed_ones;
  wire logic [31:0]       unmask_bits;
  wire logic [31:0]       mask_set_bits;
  wire logic [31:0]       mask_read;
  wire logic [31:0]       grp_vec;
  wire logic [31:0]       notify_vec;

  assign awready = (wr_state_ff == imc_pkg::IMC_WR_IDLE) && !aw_held_ff;
  assign wready  = (wr_state_ff == imc_pkg::IMC_WR_IDLE) && !w_held_ff;
  assign arready = (rd_state_ff == imc_pkg::IMC_RD_IDLE);
  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign ar_take = arvalid && arready;

  // Address and data may arrive in either order or together
  assign wr_go   = (aw_take || aw_held_ff) && (w_take || w_held_ff);
  assign wr_addr = aw_held_ff ? waddr_ff : awaddr;
  assign wr_data = w_held_ff ? wdata_ff : wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : wstrb;
  assign wr_hit  = reg_hit(wr_addr);
  assign rd_hit  = reg_hit(araddr);
  assign wr_bits = wr_data & lane_mask(wr_strb);

  // Implemented mask bits; bus groups drop out on the reduced variant
  assign impl_bits  = HAS_TT_BUS ? imc_pkg::MASK_ONE_IMPL
                                 : (imc_pkg::MASK_ONE_IMPL & ~imc_pkg::MASK_ONE_TT_BUS);
  assign fixed_ones = ~impl_bits;

  // Ones in the strobe unmask, zeros have no effect
  assign unmask_bits = (wr_go && wr_hit[5]) ? (wr_bits & impl_bits) : 32'h00000000; // [RULE1] [RULE3]

  // Plain writes to the mask register honour byte lanes
  assign mask_set_bits = lane_mask(wr_strb) & impl_bits;

  // Reserved mask bits always read one
  assign mask_read = mask_one_ff | fixed_ones;

  // Group request lines placed at their mask bit positions
  localparam int POS_PERIPH_DATA_ACCESS_GROUP_P1 = imc_pkg::POS_PERIPH_DATA_ACCESS_GROUP + 1;
  assign grp_vec[31:POS_PERIPH_DATA_ACCESS_GROUP_P1] = '0;
  assign grp_vec[imc_pkg::POS_PERIPH_DATA_ACCESS_GROUP] = grp_req.periph_data_access_group; // [RULE5]
  assign grp_vec[imc_pkg::POS_TT_TIMER] = grp_req.tt_bus_timer_group; // [RULE5]
  assign grp_vec[imc_pkg::POS_TT_CTRL] = grp_req.tt_bus_ctrl_group; // [RULE5]
  assign grp_vec[15] = 1'b0;
  assign grp_vec[imc_pkg::POS_CAN_LO+4:imc_pkg::POS_CAN_LO] = grp_req.can_group; // [RULE7]
  assign grp_vec[imc_pkg::POS_OUT_LO+9:imc_pkg::POS_OUT_LO] = grp_req.out_unit_group; // [RULE8]

  // Masked groups never reach the CPU
  assign notify_vec = grp_vec & ~mask_read; // [RULE23]

  // Write channel sequencing
  always_comb
  begin
    nxt_wr_state = wr_state_ff;
    nxt_aw_held  = aw_held_ff;
    nxt_w_held   = w_held_ff;
    nxt_waddr    = waddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb    = wstrb_ff;
    nxt_bresp    = bresp_ff;
    case (wr_state_ff)
      imc_pkg::IMC_WR_IDLE:
      begin
        if (aw_take)
        begin
          nxt_waddr   = awaddr;
          nxt_aw_held = 1'b1;
        end
        if (w_take)
        begin
          nxt_wdata  = wdata;
          nxt_wstrb  = wstrb;
          nxt_w_held = 1'b1;
        end
        if (wr_go)
        begin
          nxt_aw_held  = 1'b0;
          nxt_w_held   = 1'b0;
          nxt_bresp    = (wr_hit != '0) ? imc_pkg::RESP_OKAY : imc_pkg::RESP_SLVERR;
          nxt_wr_state = imc_pkg::IMC_WR_RESP;
        end
      end
      imc_pkg::IMC_WR_RESP:
      begin
        if (bready)
        begin
          nxt_wr_state = imc_pkg::IMC_WR_IDLE;
        end
      end
      default:
      begin
        nxt_wr_state = imc_pkg::IMC_WR_IDLE;
      end
    endcase
  end

  // Mask register: all ones at reset, written directly or cleared by the strobe
  always_comb
  begin
    nxt_mask_one = mask_one_ff;
    if (wr_go && wr_hit[4])
    begin
      nxt_mask_one = (mask_one_ff & ~mask_set_bits) | (wr_data & mask_set_bits);
    end
    nxt_mask_one = (nxt_mask_one & ~unmask_bits) | fixed_ones; // [RULE1] [RULE3]
  end

  // Source views track request levels; bus writes never reach them
  always_comb
  begin
    nxt_view[0] = 32'h00000000; // [RULE13] [RULE25]
    nxt_view[0][imc_pkg::POS_ITMR_LO+2:imc_pkg::POS_ITMR_LO] = src_req.interval_timer_underflow; // [RULE13]
    nxt_view[1] = 32'h00000000; // [RULE15] [RULE25]
    nxt_view[1][imc_pkg::POS_DMA_DN_HI+1:imc_pkg::POS_DMA_DN_HI] = src_req.dma_ch11_10_done; // [RULE14]
    nxt_view[1][imc_pkg::POS_DMA_HF_HI+3:imc_pkg::POS_DMA_HF_HI] = src_req.dma_ch9_6_done_or_half; // [RULE15]
    nxt_view[1][imc_pkg::POS_DMA_DN_LO+1:imc_pkg::POS_DMA_DN_LO] = src_req.dma_ch5_4_done; // [RULE14]
    nxt_view[1][imc_pkg::POS_DMA_AERR+1:imc_pkg::POS_DMA_AERR] = src_req.dma_ctrl_addr_error; // [RULE16]
    nxt_view[1][imc_pkg::POS_DMA_HF_LO+3:imc_pkg::POS_DMA_HF_LO] = src_req.dma_ch3_0_done_or_half; // [RULE15]
    nxt_view[2] = 32'h00000000; // [RULE17] [RULE20] [RULE21]
    nxt_view[2][imc_pkg::POS_TG_CMP+5:imc_pkg::POS_TG_CMP] = src_req.timer_g_compare_match; // [RULE17]
    nxt_view[2][imc_pkg::POS_TF_OVF+3:imc_pkg::POS_TF_OVF] = src_req.timer_f_overflow; // [RULE18]
    nxt_view[2][imc_pkg::POS_TF_CAP+3:imc_pkg::POS_TF_CAP] = src_req.timer_f_capture; // [RULE19]
    nxt_view[2][imc_pkg::POS_TA1_OVF] = src_req.timer_a1_overflow; // [RULE20]
    nxt_view[2][imc_pkg::POS_TA1_CAP+5:imc_pkg::POS_TA1_CAP] = src_req.timer_a1_capture; // [RULE20]
    nxt_view[2][imc_pkg::POS_TA0_OVF] = src_req.timer_a0_overflow; // [RULE21]
    nxt_view[2][imc_pkg::POS_TA0_CAP+5:imc_pkg::POS_TA0_CAP] = src_req.timer_a0_capture; // [RULE21]
    nxt_view[3] = 32'h00000000; // [RULE25]
    nxt_view[3][imc_pkg::POS_UNF_LO+23:imc_pkg::POS_UNF_LO] = src_req.out_unit_underflow; // [RULE22]
  end

  // Read channel; the strobe register reads as zero
  always_comb
  begin
    nxt_rd_state = rd_state_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    case (rd_state_ff)
      imc_pkg::IMC_RD_IDLE:
      begin
        if (ar_take)
        begin
          nxt_rd_state = imc_pkg::IMC_RD_DATA;
          nxt_rresp    = imc_pkg::RESP_OKAY;
          if (rd_hit[0])
          begin
            nxt_rdata = view_ff[0]; // [RULE10] [RULE12]
          end
          else if (rd_hit[1])
          begin
            nxt_rdata = view_ff[1]; // [RULE10] [RULE12]
          end
          else if (rd_hit[2])
          begin
            nxt_rdata = view_ff[2]; // [RULE10] [RULE12]
          end
          else if (rd_hit[3])
          begin
            nxt_rdata = view_ff[3]; // [RULE10] [RULE12]
          end
          else if (rd_hit[4])
          begin
            nxt_rdata = mask_read;
          end
          else if (rd_hit[5])
          begin
            nxt_rdata = imc_pkg::RST_UNMASK_ONE; // [RULE2]
          end
          else
          begin
            nxt_rdata = 32'h00000000;
            nxt_rresp = imc_pkg::RESP_SLVERR;
          end
        end
      end
      imc_pkg::IMC_RD_DATA:
      begin
        if (rready)
        begin
          nxt_rd_state = imc_pkg::IMC_RD_IDLE;
        end
      end
      default:
      begin
        nxt_rd_state = imc_pkg::IMC_RD_IDLE;
      end
    endcase
  end

  assign nxt_notify = notify_vec[imc_pkg::POS_PERIPH_DATA_ACCESS_GROUP:0] == '0 ? '0 :
                      {notify_vec[imc_pkg::POS_PERIPH_DATA_ACCESS_GROUP:imc_pkg::POS_TT_CTRL],
                       notify_vec[imc_pkg::POS_CAN_LO+4:0]};

  // Flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_ff <= imc_pkg::IMC_WR_IDLE;
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      waddr_ff    <= 32'h00000000;
      wdata_ff    <= 32'h00000000;
      wstrb_ff    <= 4'h0;
      bresp_ff    <= imc_pkg::RESP_OKAY;
    end
    else
    begin
      wr_state_ff <= nxt_wr_state;
      aw_held_ff  <= nxt_aw_held;
      w_held_ff   <= nxt_w_held;
      waddr_ff    <= nxt_waddr;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      bresp_ff    <= nxt_bresp;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_ff <= imc_pkg::IMC_RD_IDLE;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= imc_pkg::RESP_OKAY;
    end
    else
    begin
      rd_state_ff <= nxt_rd_state;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mask_one_ff <= imc_pkg::RST_MASK_ONE; // [RULE23]
      notify_ff   <= '0;
    end
    else
    begin
      mask_one_ff <= nxt_mask_one;
      notify_ff   <= nxt_notify;
    end
  end

  // One view register per source group
  for (genvar gi = 0; gi < 4; gi++)
  begin : g_view
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        view_ff[gi] <= imc_pkg::RST_VIEW; // [RULE9]
      end
      else
      begin
        view_ff[gi] <= nxt_view[gi]; // [RULE24]
      end
    end
  end

  assign bvalid     = (wr_state_ff == imc_pkg::IMC_WR_RESP);
  assign bresp      = bresp_ff;
  assign rvalid     = (rd_state_ff == imc_pkg::IMC_RD_DATA);
  assign rdata      = rdata_ff;
  assign rresp      = rresp_ff;
  assign grp_notify = notify_ff;

endmodule

// File: testbench/imc_irq_view_chk.sv
// Checker for the group unmask and source view block.
// Assumes binding onto imc_irq_view; sees only its ports.
`timescale 1ns/10ps
module imc_irq_view_chk (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [1:0]        bresp,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       araddr,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire imc_pkg::imc_grp_s grp_req,
  input wire imc_pkg::imc_grp_s grp_notify
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [31:0] rd_addr_ff;

  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
      rd_addr_ff <= araddr;
  end

  wire rd_v0 = rvalid && rd_addr_ff == imc_pkg::ADDR_ITMR_VIEW;
  wire rd_v1 = rvalid && rd_addr_ff == imc_pkg::ADDR_DMA_VIEW;
  wire rd_v2 = rvalid && rd_addr_ff == imc_pkg::ADDR_CAP_VIEW;
  wire rd_v3 = rvalid && rd_addr_ff == imc_pkg::ADDR_UNF_VIEW;
  wire rd_st = rvalid && rd_addr_ff == imc_pkg::ADDR_UNMASK_ONE;

  chk_view0_unused: assert property (rd_v0 |-> rdata[31:3] == '0)
    else $error("view 0 unused bits set");
  chk_view1_unused: assert property (rd_v1 |-> rdata[31:14] == '0)
    else $error("view 1 unused bits set");
  chk_view2_unused: assert property (rd_v2 |-> {rdata[31:30], rdata[15], rdata[7]} == '0)
    else $error("view 2 unused bits set");
  chk_view3_unused: assert property (rd_v3 |-> rdata[31:24] == '0)
    else $error("view 3 unused bits set");
  chk_strobe_reads_zero: assert property (rd_st |-> rdata == '0)
    else $error("unmask strobe read not zero");
  chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_reset_state: assert property ($rose(aresetn) |-> !bvalid && !rvalid && grp_notify == '0)
    else $error("outputs not quiet after reset");
  chk_notify_gate: assert property ((grp_notify & ~$past(grp_req)) == '0)
    else $error("notify without group request");

  cover property (bvalid && bready);
  cover property (rd_v3 && rready && rdata != '0);
  cover property (grp_notify != '0);
endmodule

bind imc_irq_view imc_irq_view_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .grp_req(grp_req), .grp_notify(grp_notify));

// File: testbench/imc_periph_model.sv
// Peripheral side: level request lines with per-source enables.
// Assumes commands from the bench on aclk.
`timescale 1ns/10ps
module imc_periph_model (
  input  wire logic              aclk,
  input  wire imc_pkg::imc_src_s src_cmd,
  input  wire imc_pkg::imc_src_s src_en,
  input  wire imc_pkg::imc_grp_s grp_cmd,
  output      imc_pkg::imc_src_s src_req,
  output      imc_pkg::imc_grp_s grp_req
);
  always_ff @(posedge aclk)
  begin
    src_req <= src_cmd & src_en;
    grp_req <= grp_cmd;
  end
endmodule

// File: testbench/irq_mask_clear_and_source_view_tb.sv
// Bench for the group unmask and source view block.
// Assumes AXI4-Lite tasks as the only register path.
`timescale 1ns/10ps
module irq_mask_clear_and_source_view_tb;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       awaddr, wdata, araddr, rdata, rd, rdata2;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rsp;
  imc_pkg::imc_src_s src_cmd, src_en, src_req;
  imc_pkg::imc_grp_s grp_cmd, grp_req, grp_notify, notify2;
  int                err_count, n_compared;

  always #20 aclk = ~aclk;

  imc_irq_view #(.HAS_TT_BUS(1'b1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .src_req(src_req), .grp_req(grp_req), .grp_notify(grp_notify));

  // Reduced variant on the same bus; only its read data and notify are watched
  imc_irq_view #(.HAS_TT_BUS(1'b0)) u_dut_red (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb),
    .bvalid(), .bready(bready), .bresp(), .arvalid(arvalid), .arready(),
    .araddr(araddr), .arprot(3'h0), .rvalid(), .rready(rready), .rdata(rdata2),
    .rresp(), .src_req(src_req), .grp_req(grp_req), .grp_notify(notify2));

  imc_periph_model u_far (.aclk(aclk), .src_cmd(src_cmd), .src_en(src_en), .grp_cmd(grp_cmd),
    .src_req(src_req), .grp_req(grp_req));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      err_count++;
      $display("BAD t=%0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic hang;
    err_count++;
    $display("BAD t=%0t handshake timeout", $time);
    final_report();
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ahs, whs, bhs;
    int   n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ahs = (awvalid & awready) === 1'b1;
      whs = (wvalid & wready) === 1'b1;
      bhs = (bvalid & bready) === 1'b1;
      r = bresp;
      @(posedge aclk);
      if (ahs) awvalid <= 1'b0;
      if (whs) wvalid <= 1'b0;
      if (bhs) bready <= 1'b0;
      n++;
    end
    while (!bhs && n < 40);
    if (!bhs) hang();
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ahs, dn;
    int   n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ahs = (arvalid & arready) === 1'b1;
      dn = (rvalid & rready) === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ahs) arvalid <= 1'b0;
      if (dn) rready <= 1'b0;
      n++;
    end
    while (!dn && n < 40);
    if (!dn) hang();
  endtask

  function automatic logic [31:0] vexp(input imc_pkg::imc_src_s s, input int k);
    case (k)
      0: return {29'h0, s.interval_timer_underflow};
      1: return {18'h0, s.dma_ch11_10_done, s.dma_ch9_6_done_or_half, s.dma_ch5_4_done,
                 s.dma_ctrl_addr_error, s.dma_ch3_0_done_or_half};
      2: return {2'h0, s.timer_g_compare_match, s.timer_f_overflow, s.timer_f_capture, 1'b0,
                 s.timer_a1_overflow, s.timer_a1_capture, 1'b0, s.timer_a0_overflow, s.timer_a0_capture};
      default: return {8'h0, s.out_unit_underflow};
    endcase
  endfunction

  task automatic check_idle;
    for (int k = 0; k < 4; k++)
    begin
      axi_rd(imc_pkg::ADDR_ITMR_VIEW + 32'(4 * k), rd, rsp);
      chk(rd, 32'h0);
    end
    axi_rd(imc_pkg::ADDR_UNMASK_ONE, rd, rsp);
    chk(rd, 32'h0);
    axi_rd(imc_pkg::ADDR_MASK_ONE, rd, rsp);
    chk(rd, 32'hffffffff);
    chk(rdata2, 32'hffffffff);
    chk(32'(grp_notify), 32'h0);
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0;
    src_cmd = '0;
    src_en = '1;
    grp_cmd = '1;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    check_idle();
    // Each implemented unmask bit alone
    for (int b = 0; b < 19; b++)
    begin
      if (b == 15) continue;
      axi_wr(imc_pkg::ADDR_MASK_ONE, 32'hffffffff, rsp);
      axi_wr(imc_pkg::ADDR_UNMASK_ONE, 32'h1 << b, rsp);
      chk({30'h0, rsp}, {30'h0, imc_pkg::RESP_OKAY});
      axi_rd(imc_pkg::ADDR_MASK_ONE, rd, rsp);
      chk(rd, ~(32'h1 << b));
      chk(rdata2, ~(32'h1 << b) | (b == 16 || b == 17 ? imc_pkg::MASK_ONE_TT_BUS : 32'h0));
      axi_rd(imc_pkg::ADDR_UNMASK_ONE, rd, rsp);
      chk(rd, 32'h0);
      chk(32'(grp_notify), 32'h1 << (b > 15 ? b - 1 : b));
      chk(32'(notify2), (b == 16 || b == 17) ? 32'h0 : 32'h1 << (b > 15 ? b - 1 : b));
    end
    axi_wr(imc_pkg::ADDR_UNMASK_ONE, 32'h0, rsp);
    axi_rd(imc_pkg::ADDR_MASK_ONE, rd, rsp);
    chk(rd, ~(32'h1 << 18));
    // Walk one request through every source with all groups masked
    axi_wr(imc_pkg::ADDR_MASK_ONE, 32'hffffffff, rsp);
    for (int j = 0; j < 69; j++)
    begin
      src_cmd <= imc_pkg::imc_src_s'(69'h1 << j);
      repeat (3) @(posedge aclk);
      for (int k = 0; k < 4; k++)
      begin
        axi_rd(imc_pkg::ADDR_ITMR_VIEW + 32'(4 * k), rd, rsp);
        chk(rd, vexp(src_cmd, k));
      end
    end
    // Writes to views are ignored
    src_cmd <= '1;
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(imc_pkg::ADDR_ITMR_VIEW + 32'(4 * k), 32'h0, rsp);
      chk({30'h0, rsp}, {30'h0, imc_pkg::RESP_OKAY});
      axi_rd(imc_pkg::ADDR_ITMR_VIEW + 32'(4 * k), rd, rsp);
      chk(rd, vexp('1, k));
    end
    // Unmapped address
    axi_rd(32'hfffff450, rd, rsp);
    chk({rd[29:0], rsp}, {30'h0, imc_pkg::RESP_SLVERR});
    axi_wr(32'hfffff450, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, imc_pkg::RESP_SLVERR});
    // Second reset in mid-run, with every group unmasked beforehand
    axi_wr(imc_pkg::ADDR_UNMASK_ONE, imc_pkg::MASK_ONE_IMPL, rsp);
    src_cmd <= '0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check_idle();
    final_report();
  end
endmodule
